// File: logic/bcri_consts.vh
// Constants for the branch, call, return and interrupt control block.
`ifndef BCRI_CONSTS_VH
`define BCRI_CONSTS_VH
// ======================================================================
// Register byte offsets
`define BCRI_ADDR_INSTR 8'h00
`define BCRI_ADDR_PC 8'h04
`define BCRI_ADDR_JTR 8'h08
`define BCRI_ADDR_STATE 8'h0C
`define BCRI_ADDR_SRC_EN 8'h10
`define BCRI_ADDR_SRC_REQ 8'h14
`define BCRI_ADDR_EVT 8'h18
`define BCRI_ADDR_EVT_MASK 8'h1C
`define BCRI_ADDR_PSW 8'h20
// ======================================================================
// Operation codes in bits 15 to 11
`define BCRI_OP_NOP 5'h00
`define BCRI_OP_GROUP 5'h07
`define BCRI_OP_JUMP_LOW 5'h0C
`define BCRI_OP_JUMP_HIGH 5'h0D
`define BCRI_OP_CALL 5'h1D
// ======================================================================
// Group codes: bits 10 to 8 followed by bits 7 to 4
`define BCRI_G_JUMP_JTR 7'h04
`define BCRI_G_CALL_JTR 7'h05
`define BCRI_G_RET 7'h0E
`define BCRI_G_RETURN_AND_SKIP_OP 7'h1E
`define BCRI_G_RETURN_FROM_INTERRUPT_OP 7'h4E
`define BCRI_G_INT_EN 7'h0F
`define BCRI_G_INT_DIS 7'h1F
`define BCRI_G_STOP 7'h2F
`define BCRI_G_HALT 7'h3F
// ======================================================================
// Event status bit positions
`define BCRI_EVT_ACCEPT 0
`define BCRI_EVT_HALT 1
`define BCRI_EVT_STOP 2
`define BCRI_EVT_UNKNOWN 3
`define BCRI_EVT_WAKE 4
`define BCRI_EVT_W 5
// ======================================================================
// Reset values, restore mask and interrupt status bits set on service
`define BCRI_PC_RST 16'h0000
`define BCRI_PSW_RST 4'h0
`define BCRI_INTERRUPT_STATUS_BITS_RST 4'h0
`define BCRI_PSW_RESTORE 4'hE
`define BCRI_INTERRUPT_STATUS_BITS_SERVICE 4'h1
`endif

// File: logic/bcri_ctrl.v
// Control-flow execution unit: jumps, calls, returns, interrupts and low-power entry.
`timescale 1ns/10ps
`include "bcri_consts.vh"

module bcri_ctrl #(
   parameter NSRC = 4,
   parameter SPW = 3,
   parameter [15:0] VEC_BASE = 16'h0001
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [NSRC-1:0] src_req_in,
   input wire [3:0] wake_in,
   output reg irq,
   output reg [15:0] program_counter,
   output reg global_interrupt_enable,
   output reg halt_mode,
   output reg stop_mode
);

   localparam DEPTH = 1 << SPW;
   localparam [SPW-1:0] SP_ONE = {{(SPW-1){1'h0}}, 1'h1};

   // ===================================================================
   // State
   reg [15:0] address_stack_entry [0:DEPTH-1];
   reg [3:0] saved_interrupt_status [0:DEPTH-1];
   reg [3:0] saved_psw [0:DEPTH-1];
   reg [SPW-1:0] stack_index;
   reg [15:0] jump_target_register;
   reg [15:0] last_instr;
   reg [3:0] program_status_word;
   reg [3:0] interrupt_status_bits;
   reg [3:0] wake_cond;
   reg page_select;
   reg [NSRC-1:0] source_interrupt_enable;
   reg [NSRC-1:0] source_interrupt_request;
   reg [`BCRI_EVT_W-1:0] evt_status;
   reg [`BCRI_EVT_W-1:0] evt_mask;
   reg [`BCRI_EVT_W-1:0] evt_set;
   reg [31:0] rdata;
   reg mapped;
   reg read_only;
   reg known_op;
   reg acc_hit;
   reg [3:0] acc_idx;
   integer i;

   wire access = psel & penable;
   wire done = access & pready;
   wire low_power = halt_mode | stop_mode;
   wire instr_hit = (paddr == `BCRI_ADDR_INSTR);
   wire exec = done & pwrite & instr_hit & ~low_power & ~pslverr;
   wire [15:0] instr = pwdata[15:0];
   wire [4:0] opc = instr[15:11];
   wire [6:0] grp = instr[10:4];
   wire [15:0] pc_next = program_counter + 16'h0001;
   wire [SPW-1:0] sp_dec = stack_index - SP_ONE;
   wire [SPW-1:0] sp_inc = stack_index + SP_ONE;
   wire [NSRC-1:0] pending = source_interrupt_request & source_interrupt_enable;
   wire take_int = global_interrupt_enable & acc_hit & ~exec & ~low_power;
   wire wake = low_power & (|(wake_cond & wake_in));
   wire evt_read = done & ~pwrite & (paddr == `BCRI_ADDR_EVT);
   wire call_op = exec && ((opc == `BCRI_OP_CALL)
      || (opc == `BCRI_OP_GROUP && grp == `BCRI_G_CALL_JTR));
   wire push_en = take_int | call_op;
   wire [15:0] push_val = take_int ? program_counter : pc_next;

   // ===================================================================
   // Interrupt source selection
   always @* begin
      acc_hit = 1'b0;
      acc_idx = 4'h0;
      for (i = NSRC - 1; i >= 0; i = i - 1) begin
         if (pending[i]) begin
            acc_hit = 1'b1;
            acc_idx = i[3:0];
         end
      end
   end

   // ===================================================================
   // Request flags
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : gen_req
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               source_interrupt_request[g] <= 1'b0;
            end else begin
               source_interrupt_request[g] <= (source_interrupt_request[g]
                  & ~(take_int && acc_idx == g)) | src_req_in[g];
            end
         end
      end
   endgenerate

   // ===================================================================
   // Register read decode
   always @* begin
      rdata = 32'h0000_0000;
      mapped = 1'b1;
      read_only = 1'b0;
      case (paddr)
         `BCRI_ADDR_INSTR: rdata[15:0] = last_instr;
         `BCRI_ADDR_PC: begin
            rdata[15:0] = program_counter;
            read_only = 1'b1;
         end
         `BCRI_ADDR_JTR: rdata[15:0] = jump_target_register;
         `BCRI_ADDR_STATE: begin
            rdata[SPW-1:0] = stack_index;
            rdata[8] = page_select;
            rdata[9] = global_interrupt_enable;
            rdata[10] = halt_mode;
            rdata[11] = stop_mode;
            rdata[15:12] = wake_cond;
            read_only = 1'b1;
         end
         `BCRI_ADDR_SRC_EN: rdata[NSRC-1:0] = source_interrupt_enable;
         `BCRI_ADDR_SRC_REQ: begin
            rdata[NSRC-1:0] = source_interrupt_request;
            read_only = 1'b1;
         end
         `BCRI_ADDR_EVT: begin
            rdata[`BCRI_EVT_W-1:0] = evt_status;
            read_only = 1'b1;
         end
         `BCRI_ADDR_EVT_MASK: rdata[`BCRI_EVT_W-1:0] = evt_mask;
         `BCRI_ADDR_PSW: begin
            rdata[3:0] = program_status_word;
            rdata[7:4] = interrupt_status_bits;
         end
         default: mapped = 1'b0;
      endcase
   end

   // ===================================================================
   // Bus answer and execution
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         program_counter <= `BCRI_PC_RST;
         global_interrupt_enable <= 1'b0;
         halt_mode <= 1'b0;
         stop_mode <= 1'b0;
         stack_index <= {SPW{1'h0}};
         jump_target_register <= 16'h0000;
         last_instr <= 16'h0000;
         program_status_word <= `BCRI_PSW_RST;
         interrupt_status_bits <= `BCRI_INTERRUPT_STATUS_BITS_RST;
         wake_cond <= 4'h0;
         page_select <= 1'b0;
         source_interrupt_enable <= {NSRC{1'h0}};
         evt_mask <= {`BCRI_EVT_W{1'h0}};
      end else begin
         pready <= access & ~pready;
         if (access & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rdata;
            pslverr <= ~mapped | (pwrite & read_only) | (pwrite & instr_hit & low_power);
         end else begin
            pslverr <= 1'b0;
         end
         if (done & pwrite & mapped) begin
            case (paddr)
               `BCRI_ADDR_JTR: jump_target_register <= pwdata[15:0];
               `BCRI_ADDR_SRC_EN: source_interrupt_enable <= pwdata[NSRC-1:0];
               `BCRI_ADDR_EVT_MASK: evt_mask <= pwdata[`BCRI_EVT_W-1:0];
               `BCRI_ADDR_PSW: begin
                  program_status_word <= pwdata[3:0];
                  interrupt_status_bits <= pwdata[7:4];
               end
               default: last_instr <= last_instr;
            endcase
         end
         if (wake) begin
            halt_mode <= 1'b0;
            stop_mode <= 1'b0;
         end
         if (take_int) begin
            stack_index <= sp_dec;
            interrupt_status_bits <= interrupt_status_bits | `BCRI_INTERRUPT_STATUS_BITS_SERVICE;
            global_interrupt_enable <= 1'b0;
            program_counter <= VEC_BASE + {12'h000, acc_idx};
         end else if (exec) begin
            last_instr <= instr;
            program_counter <= pc_next;
            case (opc)
               `BCRI_OP_NOP: program_counter <= pc_next;
               `BCRI_OP_JUMP_LOW: begin
                  program_counter <= {5'h00, instr[10:0]};
                  page_select <= 1'b0;
               end
               `BCRI_OP_JUMP_HIGH: begin
                  program_counter <= {4'h0, 1'h1, instr[10:0]};
                  page_select <= 1'b1;
               end
               `BCRI_OP_CALL: begin
                  stack_index <= sp_dec;
                  program_counter <= {5'h00, instr[10:0]};
                  page_select <= 1'b0;
               end
               `BCRI_OP_GROUP: begin
                  case (grp)
                     `BCRI_G_JUMP_JTR: program_counter <= jump_target_register;
                     `BCRI_G_CALL_JTR: begin
                        stack_index <= sp_dec;
                        program_counter <= jump_target_register;
                     end
                     `BCRI_G_RET: begin
                        program_counter <= address_stack_entry[stack_index];
                        stack_index <= sp_inc;
                     end
                     `BCRI_G_RETURN_AND_SKIP_OP: begin
                        program_counter <= address_stack_entry[stack_index] + 16'h0001;
                        stack_index <= sp_inc;
                     end
                     `BCRI_G_RETURN_FROM_INTERRUPT_OP: begin
                        program_counter <= address_stack_entry[stack_index];
                        interrupt_status_bits <= saved_interrupt_status[stack_index];
                        program_status_word <= (program_status_word & ~`BCRI_PSW_RESTORE)
                           | (saved_psw[stack_index] & `BCRI_PSW_RESTORE);
                        stack_index <= sp_inc;
                     end
                     `BCRI_G_INT_EN: global_interrupt_enable <= 1'b1;
                     `BCRI_G_INT_DIS: global_interrupt_enable <= 1'b0;
                     `BCRI_G_STOP: begin
                        stop_mode <= 1'b1;
                        wake_cond <= instr[3:0];
                     end
                     `BCRI_G_HALT: begin
                        halt_mode <= 1'b1;
                        wake_cond <= instr[3:0];
                     end
                     default: program_counter <= pc_next;
                  endcase
               end
               default: program_counter <= pc_next;
            endcase
         end
      end
   end

   // ===================================================================
   // Address stack storage
   always @(posedge pclk) begin
      if (push_en) begin
         address_stack_entry[sp_dec] <= push_val;
      end
      if (take_int) begin
         saved_interrupt_status[sp_dec] <= interrupt_status_bits;
         saved_psw[sp_dec] <= program_status_word;
      end
   end

   // ===================================================================
   // Instruction recognition
   always @* begin
      known_op = 1'b0;
      case (opc)
         `BCRI_OP_NOP: known_op = 1'b1;
         `BCRI_OP_JUMP_LOW: known_op = 1'b1;
         `BCRI_OP_JUMP_HIGH: known_op = 1'b1;
         `BCRI_OP_CALL: known_op = 1'b1;
         `BCRI_OP_GROUP: begin
            case (grp)
               `BCRI_G_JUMP_JTR: known_op = 1'b1;
               `BCRI_G_CALL_JTR: known_op = 1'b1;
               `BCRI_G_RET: known_op = 1'b1;
               `BCRI_G_RETURN_AND_SKIP_OP: known_op = 1'b1;
               `BCRI_G_RETURN_FROM_INTERRUPT_OP: known_op = 1'b1;
               `BCRI_G_INT_EN: known_op = 1'b1;
               `BCRI_G_INT_DIS: known_op = 1'b1;
               `BCRI_G_STOP: known_op = 1'b1;
               `BCRI_G_HALT: known_op = 1'b1;
               default: known_op = 1'b0;
            endcase
         end
         default: known_op = 1'b0;
      endcase
   end

   // ===================================================================
   // Event status, mask and interrupt output
   always @* begin
      evt_set = {`BCRI_EVT_W{1'h0}};
      evt_set[`BCRI_EVT_ACCEPT] = take_int;
      evt_set[`BCRI_EVT_HALT] = exec && opc == `BCRI_OP_GROUP && grp == `BCRI_G_HALT;
      evt_set[`BCRI_EVT_STOP] = exec && opc == `BCRI_OP_GROUP && grp == `BCRI_G_STOP;
      evt_set[`BCRI_EVT_UNKNOWN] = exec && !known_op;
      evt_set[`BCRI_EVT_WAKE] = wake;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_status <= {`BCRI_EVT_W{1'h0}};
         irq <= 1'b0;
      end else begin
         evt_status <= (evt_read ? {`BCRI_EVT_W{1'h0}} : evt_status) | evt_set;
         irq <= |(((evt_read ? {`BCRI_EVT_W{1'h0}} : evt_status) | evt_set) & evt_mask);
      end
   end

endmodule // bcri_ctrl

// File: testbench/bcri_ctrl_monitor.sv
// Port checker for the control-flow unit.
`timescale 1ns/10ps
`include "bcri_consts.vh"
module bcri_ctrl_monitor (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire [15:0] program_counter,
   input wire global_interrupt_enable,
   input wire halt_mode,
   input wire stop_mode
);
   // ==========================================================
   // Helper logic
   reg [31:0] prev_wd;
   wire done = psel && penable && pready;
   wire ex = done && pwrite && paddr == `BCRI_ADDR_INSTR && !halt_mode && !stop_mode
      && !pslverr;
   always @(posedge pclk) begin
      prev_wd <= pwdata;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========================================================
   // Assertions
   a_ready_wait:
   assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("late ready");
   a_ready_single:
   assert property (pready |=> !pready) else $error("ready too long");
   a_idle_ready:
   assert property (!(psel && penable) |=> !pready) else $error("stray ready");
   a_nop_advance:
   assert property (ex && pwdata[15:0] == 16'h0000 |=>
      program_counter == $past(program_counter) + 16'h0001) else $error("no-op counter");
   a_jump_low:
   assert property (ex && pwdata[15:11] == `BCRI_OP_JUMP_LOW |=>
      program_counter == {5'h00, prev_wd[10:0]}) else $error("low jump");
   a_jump_high:
   assert property (ex && pwdata[15:11] == `BCRI_OP_JUMP_HIGH |=>
      program_counter == 16'h0800 + {5'h00, prev_wd[10:0]}) else $error("high jump");
   a_call_page:
   assert property (ex && pwdata[15:11] == `BCRI_OP_CALL |=>
      program_counter == {5'h00, prev_wd[10:0]}) else $error("call target");
   a_gie_set:
   assert property (ex && pwdata[15:0] == 16'h38F0 |=> global_interrupt_enable)
      else $error("enable flag");
   a_gie_clear:
   assert property (ex && pwdata[15:0] == 16'h39F0 |=> !global_interrupt_enable)
      else $error("disable flag");
   a_halt_enter:
   assert property (ex && pwdata[15:4] == 12'h3BF |=> halt_mode) else $error("halt entry");
   a_stop_enter:
   assert property (ex && pwdata[15:4] == 12'h3AF |=> stop_mode) else $error("stop entry");
   a_sleep_refuse:
   assert property (done && pwrite && paddr == 8'h00 && (halt_mode || stop_mode) |-> pslverr)
      else $error("sleep write taken");
endmodule // bcri_ctrl_monitor
bind bcri_ctrl bcri_ctrl_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .program_counter(program_counter),
   .global_interrupt_enable(global_interrupt_enable), .halt_mode(halt_mode),
   .stop_mode(stop_mode));

// File: testbench/bcri_ctrl_tb.sv
// Self-checking bench for the control-flow unit.
`timescale 1ns/10ps
module bcri_ctrl_tb;
   reg pclk = 1'b0;
   reg presetn = 1'b0;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0000_0000;
   reg [3:0] src_req_in = 4'h0;
   reg [3:0] wake_in = 4'h0;
   wire [31:0] prdata;
   wire pready, pslverr, irq, global_interrupt_enable, halt_mode, stop_mode;
   wire [15:0] program_counter;
   integer failures = 0;
   integer n_checks = 0;
   integer cyc = 0;
   integer mpc = 0;
   integer mjtr = 0;
   integer mgie = 0;
   integer stk[$];
   integer i;
   reg [31:0] seed = 32'h0000_0008;
   reg [31:0] rd;
   reg er;
   bcri_ctrl #(.VEC_BASE(16'h0040)) u_bcri_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_req_in(src_req_in), .wake_in(wake_in),
      .irq(irq), .program_counter(program_counter),
      .global_interrupt_enable(global_interrupt_enable), .halt_mode(halt_mode),
      .stop_mode(stop_mode));
   always #5 pclk = ~pclk;
   // ==========================================================
   // Tasks
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            failures = failures + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0) $display("STATUS OK");
         else $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         do @(posedge pclk); while (pready !== 1'b1);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(negedge pclk);
      end
   endtask
   task acc(input w, input [7:0] a, input [31:0] d, input [31:0] exp, input experr);
      begin
         apb(w, a, d);
         if (!w) chk(rd, exp);
         chk(er, experr);
      end
   endtask
   task ex(input [15:0] ins);
      begin
         apb(1'b1, 8'h00, {16'h0000, ins});
         if (ins[15:11] == 5'h0C) mpc = ins[10:0];
         else if (ins[15:11] == 5'h0D) mpc = 16'h0800 + ins[10:0];
         else if (ins[15:11] == 5'h1D || ins == 16'h3850) begin
            stk.push_front(mpc + 1);
            mpc = (ins == 16'h3850) ? mjtr : ins[10:0];
         end
         else if (ins == 16'h3840) mpc = mjtr;
         else if (ins == 16'h38E0 || ins == 16'h3CE0) mpc = stk.pop_front();
         else if (ins == 16'h39E0) mpc = stk.pop_front() + 1;
         else begin
            mpc = mpc + 1;
            if (ins == 16'h38F0) mgie = 1;
            if (ins == 16'h39F0) mgie = 0;
         end
         mpc = mpc & 32'h0000_FFFF;
         chk(program_counter, mpc);
         chk(global_interrupt_enable, mgie);
      end
   endtask
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 5000) begin
         failures = failures + 1;
         end_sim;
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk(program_counter, 16'h0000);
      acc(1'b0, 8'h0C, 0, 32'h0000_0000, 1'b0);
      acc(1'b0, 8'h40, 0, 32'h0000_0000, 1'b1);
      acc(1'b1, 8'h04, 32'h0000_1234, 0, 1'b1);
      $display("test reset done");
      ex(16'h6FFF);
      ex(16'h6800);
      for (i = 0; i < 5; i = i + 1) begin
         seed = xs(seed);
         ex({5'h0C, seed[10:0]});
         ex({5'h0D, seed[26:16]});
         mjtr = seed[31:16];
         acc(1'b1, 8'h08, {16'h0000, seed[31:16]}, 0, 1'b0);
         acc(1'b0, 8'h08, 0, mjtr, 1'b0);
         ex(16'h3840);
         ex(16'h3850);
         ex({5'h1D, seed[12:2]});
         ex(16'h0000);
         ex(16'h39E0);
         ex(16'h38E0);
         ex(16'h38F0);
         ex(16'h39F0);
      end
      $display("test flow done");
      acc(1'b1, 8'h1C, 32'h0000_0001, 0, 1'b0);
      ex(16'h38F0);
      @(posedge pclk);
      src_req_in <= 4'h4;
      @(posedge pclk);
      src_req_in <= 4'h0;
      repeat (3) @(negedge pclk);
      chk({irq, program_counter}, mpc);
      acc(1'b0, 8'h14, 0, 32'h0000_0004, 1'b0);
      acc(1'b1, 8'h10, 32'h0000_0004, 0, 1'b0);
      repeat (3) @(negedge pclk);
      stk.push_front(mpc);
      mpc = 16'h0042;
      mgie = 0;
      chk({irq, global_interrupt_enable, program_counter}, 32'h0002_0042);
      acc(1'b0, 8'h20, 0, 32'h0000_0010, 1'b0);
      acc(1'b0, 8'h18, 0, 32'h0000_0001, 1'b0);
      @(negedge pclk);
      chk(irq, 1'b0);
      acc(1'b0, 8'h0C, 0, 32'h0000_0007, 1'b0);
      acc(1'b1, 8'h20, 32'h0000_001F, 0, 1'b0);
      ex(16'h3CE0);
      acc(1'b0, 8'h20, 0, 32'h0000_0001, 1'b0);
      $display("test interrupt done");
      for (i = 0; i < 2; i = i + 1) begin
         ex(i ? 16'h3AF2 : 16'h3BF1);
         chk({stop_mode, halt_mode}, i ? 2'b10 : 2'b01);
         acc(1'b1, 8'h00, 32'h0000_0000, 0, 1'b1);
         @(posedge pclk);
         wake_in <= i ? 4'h2 : 4'h1;
         repeat (3) @(negedge pclk);
         chk({stop_mode, halt_mode}, 2'b00);
         @(posedge pclk);
         wake_in <= 4'h0;
      end
      ex(16'hF800);
      acc(1'b0, 8'h18, 0, 32'h0000_001E, 1'b0);
      $display("test low power done");
      end_sim;
   end
endmodule // bcri_ctrl_tb
